// >>> hw/axs_status_regs.v
// Audio extract status, error and channel status register bank on APB
//
// What this block does
// (R1) Status bit 4 mirrors packet asynchronous flag
// (R2) Status bits 6:5 give rate code bits
// (R3) Status bit 7 high while control packet present
// (R4) Error counter bits 3:0 counts detected errors
// (R5) Writing one to counter bits clears it
// (R6) Checksum error flag sticky, write one clears
// (R7) Any parity failure sets sticky parity flag
// (R8) Channel status CRC error flag sticky
// (R9) Packet error check CRC flag sticky
// (R10) FIFO bits 6:0 report selected FIFO fill
// (R11) FIFO bit 7 flags selected FIFO overflow, and output FIFO underflow outside stream mode
// (R12) FIFO error flag starts high after reset
// (R13) Clock bits 4:0 show digital PLL state
// (R14) Clock bit 7 high for divided video rate
// (R15) Window 10h to 3Fh reads channel status
// (R16) Direct channel status read one cycle later
// (R17) Direct FIFO clear is one-cycle pulse
// (R18) Error counter saturates at fifteen
// (R19) Clock bits 6:5 read zero, ignore writes
`timescale 1ns/100ps
`include "axs_status_map.vh"

module axs_status_regs #(
  parameter ADDR_W      = 12,
  parameter VID_WINDOW  = `AXS_VID_WINDOW,
  parameter FRAC_THRESH = `AXS_FRAC_THRESH
) (
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire [ADDR_W-1:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq,
  input  wire        acp_rx,
  input  wire        acp_present,
  input  wire [3:0]  acp_active,
  input  wire        acp_async,
  input  wire        rate_code_high_bit,
  input  wire        rate_code_low_bit,
  input  wire        err_checksum,
  input  wire        err_pkt_parity,
  input  wire        err_sample_parity,
  input  wire        err_aes_parity,
  input  wire        err_cs_crc,
  input  wire        packet_error_check_crc,
  input  wire        stream_mode,
  input  wire [6:0]  out_fifo_fill,
  input  wire [6:0]  stream_fifo_fill,
  input  wire        out_fifo_underflow,
  input  wire        out_fifo_overflow,
  input  wire        stream_fifo_overflow,
  input  wire        fifo_clear,
  input  wire [4:0]  dpll_state,
  input  wire        video_tick,
  input  wire        cs_wr,
  input  wire [5:0]  cs_wr_addr,
  input  wire [7:0]  cs_wr_data,
  input  wire [5:0]  cs_rd_addr,
  output reg  [7:0]  cs_rd_data
);

  reg  [7:0]  cs_mem [0:`AXS_CS_BYTES-1];
  reg  [3:0]  acp_active_q;
  reg         acp_async_q;
  reg         rate_hi_q;
  reg         rate_lo_q;
  reg  [3:0]  err_cnt;
  reg  [3:0]  err_flags;
  reg         fifo_err;
  reg  [`AXS_INT_W-1:0] int_status;
  reg  [`AXS_INT_W-1:0] int_mask;
  reg  [15:0] vid_ticks;
  reg  [`AXS_REF_CNT_W-1:0] ref_cnt;
  reg         video_frac;
  reg  [7:0]  next_rdata;
  reg         next_err;
  integer     i;

  wire [`AXS_IDX_W-1:0] idx =
    paddr[`AXS_ADDR_LSB+`AXS_IDX_W-1:`AXS_ADDR_LSB];
  wire aligned  = (paddr[`AXS_ADDR_LSB-1:0] == 2'h0) &&
                  (paddr[ADDR_W-1:`AXS_ADDR_LSB+`AXS_IDX_W] == 0);
  wire access   = psel & penable & ~pready;
  wire wr_done  = psel & penable & pready & pwrite & ~pslverr;
  wire wr_err   = wr_done && (idx == `AXS_IDX_ERROR_STATUS);
  wire wr_fifo  = wr_done && (idx == `AXS_IDX_FIFO_STATUS);
  wire wr_int   = wr_done && (idx == `AXS_IDX_INT_STATUS);
  wire wr_mask  = wr_done && (idx == `AXS_IDX_INT_MASK);
  // Byte position inside the channel status window
  wire [`AXS_IDX_W-1:0] cs_off = idx - `AXS_IDX_CS_FIRST;

  wire any_parity = err_pkt_parity | err_sample_parity | err_aes_parity; // R7
  wire [3:0] err_ev = {packet_error_check_crc, err_cs_crc, any_parity,
                       err_checksum};
  wire err_any  = |err_ev;
  wire fifo_ev  = stream_mode ? stream_fifo_overflow              // R11
                              : (out_fifo_underflow | out_fifo_overflow);
  wire cnt_step = err_any && (err_cnt != `AXS_ERR_CNT_MAX);
  wire [`AXS_INT_W-1:0] int_ev = {cnt_step, fifo_ev, err_ev};

  // Shared by the bus and the direct port so both see the same layout
  function [7:0] cs_read;
    input [5:0] a;
    begin
      if (a < `AXS_CS_BYTES)
        cs_read = cs_mem[a];
      else
        cs_read = 8'h00;
    end
  endfunction

  // Read decode and error answer
  always @* begin
    next_rdata = 8'h00;
    next_err   = 1'b0;
    if (!aligned) begin
      next_err = 1'b1;
    end else if (idx >= `AXS_IDX_CS_FIRST && idx <= `AXS_IDX_CS_LAST) begin
      if (pwrite)
        next_err = 1'b1;
      else
        next_rdata = cs_read(cs_off[`AXS_CS_AW-1:0]); // R15
    end else begin
      case (idx)
        `AXS_IDX_AUDIO_STATUS:
          next_rdata = {acp_present, rate_hi_q, rate_lo_q, // R1 R2 R3
                        acp_async_q, acp_active_q};
        `AXS_IDX_ERROR_STATUS:
          next_rdata = {err_flags, err_cnt};
        `AXS_IDX_FIFO_STATUS:
          next_rdata = {fifo_err, stream_mode ? stream_fifo_fill // R10
                                              : out_fifo_fill};
        `AXS_IDX_CLOCK_STATUS:
          next_rdata = {video_frac, 2'h0, dpll_state}; // R13 R14 R19
        `AXS_IDX_INT_STATUS:
          next_rdata = {2'h0, int_status};
        `AXS_IDX_INT_MASK:
          next_rdata = {2'h0, int_mask};
        default:
          next_err = 1'b1;
      endcase
    end
  end

  // APB slave: one wait state so every answer comes from a flip-flop
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready <= access;
      if (access) begin
        pslverr <= next_err;
        prdata  <= pwrite ? 32'h00000000 : {24'h000000, next_rdata};
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Fields of the latest control packet
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      acp_active_q <= 4'h0;
      acp_async_q  <= 1'b0;
      rate_hi_q    <= 1'b0;
      rate_lo_q    <= 1'b0;
    end else if (acp_rx) begin
      acp_active_q <= acp_active;
      acp_async_q  <= acp_async;                      // R1
      rate_hi_q    <= rate_code_high_bit;             // R2
      rate_lo_q    <= rate_code_low_bit;              // R2
    end
  end

  // Error counter and sticky flags; a new event wins over a clear
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      err_cnt   <= 4'h0;
      err_flags <= 4'h0;
    end else begin
      if (wr_err && (|pwdata[`AXS_ES_CNT_HI:0]))                  // R5
        err_cnt <= err_any ? 4'h1 : 4'h0;
      else if (cnt_step)                                          // R4 R18
        err_cnt <= err_cnt + 4'h1;
      if (wr_err)                                                 // R6 R7
        err_flags <= (err_flags & ~pwdata[`AXS_ES_PACKET_ERROR_CHECK_CRC:`AXS_ES_CHECKSUM])
                     | err_ev;                                    // R8 R9
      else
        err_flags <= err_flags | err_ev;                          // R6 R7
    end
  end

  // FIFO error is set from reset until software clears the FIFO
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      fifo_err <= `AXS_FIFO_ERR_RESET;                            // R12
    else if (fifo_ev)
      fifo_err <= 1'b1;                                           // R11
    else if (fifo_clear || (wr_fifo && pwdata[`AXS_FS_ERROR]))    // R17
      fifo_err <= 1'b0;
  end

  // Interrupt status, mask and level output
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      int_status <= {`AXS_INT_W{1'b0}};
      int_mask   <= {`AXS_INT_W{1'b0}};
      irq        <= 1'b0;
    end else begin
      if (wr_int)
        int_status <= (int_status & ~pwdata[`AXS_INT_W-1:0]) | int_ev;
      else
        int_status <= int_status | int_ev;
      if (wr_mask)
        int_mask <= pwdata[`AXS_INT_W-1:0];
      irq <= |(int_status & int_mask);
    end
  end

  // Video rate detector: reference cycles per window of video ticks.
  // Slower fractional video gives a longer window; threshold sits between.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      vid_ticks  <= 16'h0000;
      ref_cnt    <= {`AXS_REF_CNT_W{1'b0}};
      video_frac <= 1'b0;
    end else if (video_tick && vid_ticks == VID_WINDOW - 1) begin
      vid_ticks  <= 16'h0000;
      ref_cnt    <= {`AXS_REF_CNT_W{1'b0}};
      video_frac <= (ref_cnt > FRAC_THRESH);                      // R14
    end else begin
      if (video_tick)
        vid_ticks <= vid_ticks + 16'h0001;
      if (ref_cnt != {`AXS_REF_CNT_W{1'b1}})
        ref_cnt <= ref_cnt + 1'b1;
    end
  end

  // Channel status store, written by the extraction datapath
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < `AXS_CS_BYTES; i = i + 1)
        cs_mem[i] <= 8'h00;
    end else if (cs_wr && cs_wr_addr < `AXS_CS_BYTES) begin
      cs_mem[cs_wr_addr] <= cs_wr_data;
    end
  end

  // Direct read port, one cycle of latency
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      cs_rd_data <= 8'h00;
    else
      cs_rd_data <= cs_read(cs_rd_addr);                          // R16
  end

endmodule // axs_status_regs

// >>> hw/axs_status_map.vh
// Register map, field positions and reset values of the audio status bank
`ifndef AXS_STATUS_MAP_VH
`define AXS_STATUS_MAP_VH

// Register indices; byte address is four times the index
`define AXS_IDX_AUDIO_STATUS   7'h02
`define AXS_IDX_ERROR_STATUS   7'h04
`define AXS_IDX_FIFO_STATUS    7'h06
`define AXS_IDX_CLOCK_STATUS   7'h07
`define AXS_IDX_CS_FIRST       7'h10
`define AXS_IDX_CS_LAST        7'h3F
`define AXS_IDX_INT_STATUS     7'h40
`define AXS_IDX_INT_MASK       7'h41
`define AXS_IDX_W              7
`define AXS_ADDR_LSB           2

// Channel status RAM layout
`define AXS_CS_BYTES           48
`define AXS_CS_Y_BASE          6'h18
`define AXS_CS_AW              6

// Audio status fields
`define AXS_AS_ACTIVE_HI       3
`define AXS_AS_ASYNC           4
`define AXS_AS_RATE_LO         5
`define AXS_AS_RATE_HI         6
`define AXS_AS_VALID           7

// Error status fields
`define AXS_ES_CNT_HI          3
`define AXS_ES_CHECKSUM        4
`define AXS_ES_PARITY          5
`define AXS_ES_CS_CRC          6
`define AXS_ES_PACKET_ERROR_CHECK_CRC            7
`define AXS_ERR_CNT_MAX        4'hF

// FIFO and clock status fields
`define AXS_FS_FILL_HI         6
`define AXS_FS_ERROR           7
`define AXS_FIFO_ERR_RESET     1'b1
`define AXS_CK_DPLL_HI         4
`define AXS_CK_FRAC            7

// Interrupt bits: four error kinds, FIFO error, counter step
`define AXS_INT_W              6
`define AXS_INT_CHECKSUM       0
`define AXS_INT_PARITY         1
`define AXS_INT_CS_CRC         2
`define AXS_INT_PACKET_ERROR_CHECK_CRC           3
`define AXS_INT_FIFO           4
`define AXS_INT_COUNT          5

// Video rate detector defaults
`define AXS_VID_WINDOW         16'h03E8
`define AXS_FRAC_THRESH        24'h00A050
`define AXS_REF_CNT_W          24

`endif

// >>> bench/axs_status_regs_checker.sv
// Port-level assertions for the audio status register bank
`timescale 1ns/100ps
module axs_status_regs_checker #(parameter ADDR_W = 12) (
  input logic              ref_clk,
  input logic              nrst,
  input logic [ADDR_W-1:0] paddr,
  input logic              psel,
  input logic              penable,
  input logic              pwrite,
  input logic [31:0]       prdata,
  input logic              pready,
  input logic              pslverr,
  input logic              acp_present,
  input logic [4:0]        dpll_state,
  input logic              cs_wr,
  input logic [5:0]        cs_rd_addr,
  input logic [7:0]        cs_rd_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Read answers are judged at the pready edge
  wire rd_ok = pready && !pwrite;
  a_ready_lat: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_upper_zero: assert property (rd_ok |-> prdata[31:8] == 24'h0)
    else $error("upper bits set");
  a_valid_live: assert property (rd_ok && paddr == 'h8 &&
    acp_present && $past(acp_present) |-> prdata[7]) else $error("valid");
  a_clk_gap: assert property (rd_ok && paddr == 'h1C
    |-> prdata[6:5] == 2'h0) else $error("reserved bits set");
  a_dpll_live: assert property (rd_ok && paddr == 'h1C &&
    $stable(dpll_state) |-> prdata[4:0] == dpll_state) else $error("pll");
  a_cs_wr_refused: assert property (pready && pwrite &&
    paddr >= 'h40 && paddr <= 'hFC |-> pslverr) else $error("cs write");
  a_cs_rd_hold: assert property ($past(nrst) &&
    $stable(cs_rd_addr) && !$past(cs_wr) |=> $stable(cs_rd_data))
    else $error("cs read moved");
endmodule // axs_status_regs_checker

bind axs_status_regs axs_status_regs_checker #(.ADDR_W(ADDR_W)) chk (.*);

// >>> bench/axs_host_model.sv
// APB host model issuing single transfers to the status bank
`timescale 1ns/100ps
module axs_host_model (
  input  logic        ref_clk,
  output logic [11:0] paddr = 12'h0,
  output logic        psel = 1'h0,
  output logic        penable = 1'h0,
  output logic        pwrite = 1'h0,
  output logic [31:0] pwdata = 32'h0,
  input  logic [31:0] prdata,
  input  logic        pready,
  input  logic        pslverr
);
  // Request held until pready is seen high; no latency assumed
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule // axs_host_model

// >>> bench/axs_status_regs_tb.sv
// Self-checking bench for the audio status register bank
`timescale 1ns/100ps
module axs_status_regs_tb;
  logic ref_clk = 1'h0, nrst = 1'h0, acp_present = 1'h0, acp_async = 1'h0;
  logic rate_code_high_bit = 1'h0, rate_code_low_bit = 1'h0;
  logic stream_mode = 1'h0, cs_wr = 1'h0, psel, penable, pwrite, pready;
  logic pslverr, irq, e, acp_rx, fifo_clear, video_tick, err_checksum;
  logic out_fifo_underflow, out_fifo_overflow, stream_fifo_overflow;
  logic err_pkt_parity, err_sample_parity, err_aes_parity, err_cs_crc;
  logic packet_error_check_crc;
  logic [3:0]  acp_active = 4'hA;
  logic [4:0]  dpll_state = 5'h15;
  logic [5:0]  cs_wr_addr = 6'h0, cs_rd_addr = 6'h0;
  logic [6:0]  out_fifo_fill = 7'h05, stream_fifo_fill = 7'h2A;
  logic [7:0]  cs_wr_data = 8'h0, cs_rd_data, f;
  logic [11:0] paddr, ev = 12'h0;
  logic [31:0] pwdata, prdata, q;
  int          fail_count = 0, n_checks = 0;
  // One vector carries every event pulse into the bank
  assign {video_tick, acp_rx, fifo_clear, stream_fifo_overflow,
          out_fifo_overflow, out_fifo_underflow, packet_error_check_crc,
          err_cs_crc, err_aes_parity, err_sample_parity, err_pkt_parity,
          err_checksum} = ev;
  axs_status_regs #(.VID_WINDOW(4), .FRAC_THRESH(24)) uut (.*);
  axs_host_model host (.*);
  initial forever #12.5 ref_clk = ~ref_clk;
  task chk(input logic c);
    n_checks++;
    if (c !== 1'h1) begin
      fail_count++;
      $display("unexpected at %0t: value mismatch", $time);
    end
  endtask
  task rd(input logic [11:0] a, input logic [7:0] x, input logic xe);
    host.xfer(1'h0, a, 32'h0, q, e);
    chk(q === {24'h0, x} && e === xe);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
    host.xfer(1'h1, a, d, q, e);
    chk(e === xe);
  endtask
  task pulse(input logic [11:0] m, input int n);
    ev <= m;
    repeat (n) @(posedge ref_clk);
    ev <= 12'h0;
  endtask
  task end_sim;
    if (fail_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    end_sim;
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'h1;
    rd(12'h018, 8'h85, 1'h0);
    stream_mode <= 1'h1;
    rd(12'h018, 8'hAA, 1'h0);
    pulse(12'h200, 1);
    rd(12'h018, 8'h2A, 1'h0);
    pulse(12'h100, 1);
    rd(12'h018, 8'hAA, 1'h0);
    wr(12'h018, 32'h80, 1'h0);
    rd(12'h018, 8'h2A, 1'h0);
    stream_mode <= 1'h0;
    pulse(12'h040, 1);
    rd(12'h018, 8'h85, 1'h0);
    wr(12'h104, 32'h3F, 1'h0);
    f = 8'h00;
    for (int i = 0; i < 6; i++) begin
      pulse(12'h001 << i, 1);
      f |= i == 0 ? 8'h10 : i < 4 ? 8'h20 : i == 4 ? 8'h40 : 8'h80;
      rd(12'h010, f | 8'(i + 1), 1'h0);
    end
    chk(irq === 1'h1);
    pulse(12'h001, 20);
    rd(12'h010, 8'hFF, 1'h0);
    wr(12'h010, 32'h01, 1'h0);
    rd(12'h010, 8'hF0, 1'h0);
    wr(12'h010, 32'hF0, 1'h0);
    rd(12'h010, 8'h00, 1'h0);
    wr(12'h104, 32'h00, 1'h0);
    wr(12'h100, 32'h3F, 1'h0);
    pulse(12'h002, 1);
    repeat (3) @(posedge ref_clk);
    chk(irq === 1'h0);
    wr(12'h104, 32'h3F, 1'h0);
    repeat (2) @(posedge ref_clk);
    chk(irq === 1'h1);
    {acp_present, acp_async, rate_code_high_bit, rate_code_low_bit} <= 4'hD;
    pulse(12'h400, 1);
    rd(12'h008, 8'hBA, 1'h0);
    {acp_present, acp_async, rate_code_high_bit, rate_code_low_bit} <= 4'h2;
    pulse(12'h400, 1);
    rd(12'h008, 8'h4A, 1'h0);
    wr(12'h01C, 32'h60, 1'h0);
    rd(12'h01C, 8'h15, 1'h0);
    // Slow ticks mimic the divided video rate, fast ones the nominal
    for (int p = 10; p > 0; p -= 8) begin
      repeat (12) begin
        pulse(12'h800, 1);
        repeat (p - 1) @(posedge ref_clk);
      end
      rd(12'h01C, p > 2 ? 8'h95 : 8'h15, 1'h0);
    end
    for (int i = 0; i < 48; i++) begin
      cs_wr <= 1'h1;
      cs_wr_addr <= 6'(i);
      cs_wr_data <= 8'(i) ^ 8'h5A;
      @(posedge ref_clk);
    end
    cs_wr <= 1'h0;
    for (int i = 0; i < 48; i++) begin
      rd(12'h040 + 12'(4 * i), 8'(i) ^ 8'h5A, 1'h0);
      cs_rd_addr <= 6'(i);
      repeat (2) @(posedge ref_clk);
      chk(cs_rd_data === (8'(i) ^ 8'h5A));
    end
    rd(12'h020, 8'h00, 1'h1);
    wr(12'h040, 32'h77, 1'h1);
    rd(12'h040, 8'h5A, 1'h0);
    end_sim;
  end
endmodule // axs_status_regs_tb
